// file: rtl/otp_pkg.sv
// Constants shared by the output thermal protection block.
// Assumes a 50 MHz system clock and a 4-bit register address port.
package otp_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam int CLK_MHZ = 50;
  // Fault deglitch time, least figure treated as typical, in ns
  localparam int FAULT_DEGLITCH_TIME_NS = 5000;
  localparam int DEGLITCH_CYC = (FAULT_DEGLITCH_TIME_NS * CLK_MHZ + 999) / 1000;
  // Blanking after wake-up, typical figure, in ns
  localparam int BLANKING_TIME_NS = 50000;
  localparam int BLANKING_CYC = (BLANKING_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int DEG_W = 9;
  localparam int BLANK_W = 12;
  localparam logic [DEG_W-1:0] DEG_LAST = DEG_W'(DEGLITCH_CYC - 1);
  localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANKING_CYC);

  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_QUICK_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_FIRST = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_LAST = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_CTRL = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_INIT = 4'h9;

  // Field positions
  localparam int QS_WARN_LSB = 0;
  localparam int QS_SHUT_LSB = 4;
  localparam int CS_WARN_BIT = 0;
  localparam int CS_SHUT_BIT = 1;
  localparam int CS_ON_BIT = 2;
  localparam int CC_ON_BIT = 0;
  localparam int INIT_SEL_BIT = 0;

  localparam logic INIT_SEL_RESET = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 16'h0000;
endpackage : otp_pkg

// file: rtl/otp_thermal.sv
// Per-channel overtemperature protection for four high-side outputs.
// Assumes analog comparators deliver synchronous levels and a host drives
// the register port with one-cycle strobes.
//
// Notes on behaviour
// - Each channel has its own warning and shutdown stages, handled independently.
// - A warning never changes the output; it only records an event.
// - Warning shows in quick status and in that channel's status register.
// - Select bit 0 (reset) uses the high warning level, 1 the low one.
// - Warning flag clears only on a channel status read with temperature below.
// - Shutdown level held past the deglitch time turns off only that channel.
// - Shutdown is reported after deglitch in quick and channel status.
// - Normal mode: restart needs condition gone plus an on-bit write.
// - Shutdown flag clears only on a channel status read once condition is gone.
// - Fail mode: a tripped output restarts only on an operating-mode transition.
// - Fault detection is ignored during blanking after wake-up.
`timescale 1ns/100ps
`default_nettype none

module otp_thermal
  import otp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [NUM_CH-1:0] warning_level_low_i,
  input wire logic [NUM_CH-1:0] warning_level_high_i,
  input wire logic [NUM_CH-1:0] shutdown_level_i,
  input wire logic fail_mode_i,
  input wire logic mode_transition_i,
  input wire logic wake_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic [NUM_CH-1:0] out_en_o
);

  // ************************************************
  // Decode
  // ************************************************
  function automatic logic chan_hit(input logic [ADDR_W-1:0] a, input int ch);
    chan_hit = (a == ADDR_W'(int'(ADDR_CHAN_FIRST) + ch));
  endfunction : chan_hit

  logic warning_level_select_r;
  logic [NUM_CH-1:0] on_r;
  logic [NUM_CH-1:0] thermal_warning_r;
  logic [NUM_CH-1:0] thermal_shutdown_r;
  logic [NUM_CH-1:0] fail_lock_r;
  logic [DEG_W-1:0] deg_cnt_r [NUM_CH];
  logic [BLANK_W-1:0] blank_cnt_r;
  logic blank;
  logic [NUM_CH-1:0] warn_cond;
  logic [NUM_CH-1:0] trip;
  logic [NUM_CH-1:0] rd_hit;
  logic [NUM_CH-1:0] wr_on_req;
  logic [NUM_CH-1:0] wr_on_val;

  assign blank = (blank_cnt_r != '0);

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      warn_cond[i] = warning_level_select_r ? warning_level_low_i[i] : warning_level_high_i[i];
      trip[i] = shutdown_level_i[i] && !blank && (deg_cnt_r[i] == DEG_LAST);
      rd_hit[i] = rd_i && chan_hit(addr_i, i);
      wr_on_req[i] = wr_i && (chan_hit(addr_i, i) || addr_i == ADDR_OUTPUT_CTRL);
      wr_on_val[i] = (addr_i == ADDR_OUTPUT_CTRL) ? wdata_i[i] : wdata_i[CC_ON_BIT];
    end
  end

  // ************************************************
  // Blanking after wake-up
  // ************************************************
  // Reset counts as a wake-up, so comparators settle before any trip
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blank_cnt_r <= BLANK_LOAD;
    end else if (ce_i) begin
      if (wake_i) begin
        blank_cnt_r <= BLANK_LOAD;
      end else if (blank) begin
        blank_cnt_r <= blank_cnt_r - 1'b1;
      end
    end
  end

  // ************************************************
  // Configuration
  // ************************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      warning_level_select_r <= INIT_SEL_RESET;
    end else if (ce_i && wr_i && addr_i == ADDR_INIT) begin
      warning_level_select_r <= wdata_i[INIT_SEL_BIT];
    end
  end

  // ************************************************
  // Shutdown deglitch
  // ************************************************
  // Any drop of the level restarts the count, so only a steady excursion trips
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        deg_cnt_r[i] <= '0;
      end
    end else if (ce_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!shutdown_level_i[i] || blank || trip[i]) begin
          deg_cnt_r[i] <= '0;
        end else begin
          deg_cnt_r[i] <= deg_cnt_r[i] + 1'b1;
        end
      end
    end
  end

  // ************************************************
  // Status flags
  // ************************************************
  // Set wins over a clearing read in the same cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thermal_warning_r <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (warn_cond[i] && !blank) begin
          thermal_warning_r[i] <= 1'b1;
        end else if (rd_hit[i] && !warn_cond[i]) begin
          thermal_warning_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thermal_shutdown_r <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (trip[i]) begin
          thermal_shutdown_r[i] <= 1'b1;
        end else if (rd_hit[i] && !shutdown_level_i[i]) begin
          thermal_shutdown_r[i] <= 1'b0;
        end
      end
    end
  end

  // ************************************************
  // Output enables
  // ************************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fail_lock_r <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (trip[i] && fail_mode_i) begin
          fail_lock_r[i] <= 1'b1;
        end else if (mode_transition_i) begin
          fail_lock_r[i] <= 1'b0;
        end
      end
    end
  end

  // A locked channel comes back on the mode change itself, unless still hot
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_r <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (trip[i]) begin
          on_r[i] <= 1'b0;
        end else if (fail_lock_r[i]) begin
          on_r[i] <= mode_transition_i && !shutdown_level_i[i];
        end else if (wr_on_req[i]) begin
          on_r[i] <= wr_on_val[i] && !shutdown_level_i[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_en_o <= '0;
    end else if (ce_i) begin
      out_en_o <= on_r & ~trip;
    end
  end

  // ************************************************
  // Register read
  // ************************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= RDATA_ZERO;
    end else if (ce_i) begin
      rdata_o <= RDATA_ZERO;
      if (rd_i) begin
        if (addr_i == ADDR_QUICK_STATUS) begin
          rdata_o[QS_WARN_LSB +: NUM_CH] <= thermal_warning_r;
          rdata_o[QS_SHUT_LSB +: NUM_CH] <= thermal_shutdown_r;
        end else if (addr_i == ADDR_INIT) begin
          rdata_o[INIT_SEL_BIT] <= warning_level_select_r;
        end else if (addr_i == ADDR_OUTPUT_CTRL) begin
          rdata_o[NUM_CH-1:0] <= on_r;
        end
        for (int i = 0; i < NUM_CH; i++) begin
          if (rd_hit[i]) begin
            rdata_o[CS_WARN_BIT] <= thermal_warning_r[i];
            rdata_o[CS_SHUT_BIT] <= thermal_shutdown_r[i];
            rdata_o[CS_ON_BIT] <= on_r[i];
          end
        end
      end
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  quick_mirror_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == ADDR_QUICK_STATUS
      |=> rdata_o[QS_SHUT_LSB+NUM_CH-1:QS_WARN_LSB] == $past({thermal_shutdown_r, thermal_warning_r}))
    else $error("quick status does not mirror the flags");

  // Every wake-up restarts the blind window from its full length
  blank_load_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && wake_i |=> blank_cnt_r == BLANK_LOAD)
    else $error("blanking not restarted on wake-up");

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    trip_off_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && trip[g] |=> !out_en_o[g] && !on_r[g] && thermal_shutdown_r[g])
      else $error("tripped channel still enabled");

    shut_cause_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(thermal_shutdown_r[g]) |-> $past(shutdown_level_i[g]) && $past(deg_cnt_r[g]) == DEG_LAST)
      else $error("shutdown flag set without full deglitch");

    warn_sel_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(thermal_warning_r[g]) |-> $past(warning_level_select_r ?
        warning_level_low_i[g] : warning_level_high_i[g]))
      else $error("warning set from wrong level");

    warn_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $fell(thermal_warning_r[g]) |-> $past(rd_hit[g] && !warn_cond[g]))
      else $error("warning cleared without read");

    shut_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $fell(thermal_shutdown_r[g]) |-> $past(rd_hit[g] && !shutdown_level_i[g]))
      else $error("shutdown flag cleared early");

    restart_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(on_r[g]) |-> $past(!shutdown_level_i[g] && (wr_on_req[g] || mode_transition_i)))
      else $error("output on while hot");

    fail_lock_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && fail_lock_r[g] && !mode_transition_i |=> !on_r[g])
      else $error("locked output restarted");

    blank_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(thermal_warning_r[g]) || $rose(thermal_shutdown_r[g]) |-> !$past(blank))
      else $error("fault detected during blanking");

    deg_restart_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && !shutdown_level_i[g] |=> deg_cnt_r[g] == '0)
      else $error("deglitch count kept across a drop");

    // Only a trip, an on-bit write or the fail lock may move the on state
    warn_no_drive_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && !trip[g] && !wr_on_req[g] && !fail_lock_r[g] |=> on_r[g] == $past(on_r[g]))
      else $error("output changed without trip or write");

    chan_status_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && rd_hit[g] |=> rdata_o[CS_WARN_BIT] == $past(thermal_warning_r[g])
        && rdata_o[CS_SHUT_BIT] == $past(thermal_shutdown_r[g]))
      else $error("channel status does not mirror the flags");

    // A hot channel must not come back, whichever path asks for it
    hot_stays_off_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && shutdown_level_i[g] |=> !$rose(on_r[g]))
      else $error("hot channel turned back on");
  end

endmodule : otp_thermal

`default_nettype wire

// file: dv/otp_host.sv
// Microcontroller model: drives the register port of the thermal block.
// Assumes a free-running clock; strobes last one cycle.
`timescale 1ns/100ps
`default_nettype none

module otp_host
  import otp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [DATA_W-1:0] rdata_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 4'h0;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // On-bit write restarts a tripped channel in normal mode once its shutdown level is gone
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    // Released lines never keep the old value
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr

  // Channel status read releases latched flags whose condition is gone
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : otp_host

`default_nettype wire

// file: dv/tb_otp_thermal.sv
// Testbench for otp_thermal: scenario tasks drive comparator levels and a host model.
// Assumes the fixed 250-cycle deglitch and 2500-cycle blanking of the design.
`timescale 1ns/100ps
`default_nettype none

module tb_otp_thermal
  import otp_pkg::*;
();
  logic sys_clk = 1'b0, rst = 1'b1, fail = 1'b0, mtr = 1'b0, wake = 1'b0, ce = 1'b1;
  logic [NUM_CH-1:0] wlo = 4'h0, whi = 4'h0, sd = 4'h0, en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic wr, rd;
  int n_errors = 0, samples_checked = 0;

  always #10 sys_clk = ~sys_clk;

  otp_thermal u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .warning_level_low_i(wlo),
    .warning_level_high_i(whi), .shutdown_level_i(sd), .fail_mode_i(fail), .mode_transition_i(mtr),
    .wake_i(wake), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .out_en_o(en));
  otp_host u_host (.sys_clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  // ************************
  // Helpers
  // ************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic chk_en(input logic [NUM_CH-1:0] exp);
    samples_checked++;
    if (en !== exp) begin
      n_errors++;
      $display("ERROR t=%0t enable got %h exp %h", $time, en, exp);
    end
  endtask : chk_en

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    u_host.rd(a, d);
    samples_checked++;
    if (d !== exp) begin
      n_errors++;
      $display("ERROR t=%0t addr %h got %h exp %h", $time, a, d, exp);
    end
  endtask : chk_rd

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ************************
  // Scenarios
  // ************************
  task automatic t_warn();
    u_host.wr(ADDR_OUTPUT_CTRL, 16'h000f);
    cyc(2);
    chk_en(4'hf);
    @(posedge sys_clk) whi <= 4'h2;
    wlo <= 4'h1;
    cyc(3);
    chk_rd(ADDR_QUICK_STATUS, 16'h0002);
    chk_rd(4'h3, 16'h0005);
    chk_en(4'hf);
    @(posedge sys_clk) whi <= 4'h0;
    wlo <= 4'h0;
    chk_rd(ADDR_QUICK_STATUS, 16'h0002);
    u_host.rd(4'h3, d);
    chk_rd(4'h3, 16'h0004);
    u_host.wr(ADDR_INIT, 16'h0001);
    @(posedge sys_clk) whi <= 4'h4;
    cyc(3);
    chk_rd(ADDR_QUICK_STATUS, 16'h0000);
    @(posedge sys_clk) wlo <= 4'h4;
    cyc(3);
    chk_rd(ADDR_QUICK_STATUS, 16'h0004);
    @(posedge sys_clk) wlo <= 4'h0;
    whi <= 4'h0;
    u_host.rd(4'h4, d);
    chk_rd(4'h4, 16'h0004);
    u_host.wr(ADDR_INIT, 16'h0000);
    $display("test warn done");
  endtask : t_warn

  task automatic t_shut();
    @(posedge sys_clk) sd <= 4'h1;
    cyc(248);
    chk_en(4'hf);
    cyc(4);
    chk_en(4'he);
    chk_rd(ADDR_QUICK_STATUS, 16'h0010);
    u_host.wr(ADDR_OUTPUT_CTRL, 16'h000f);
    cyc(2);
    chk_en(4'he);
    @(posedge sys_clk) sd <= 4'h0;
    cyc(3);
    chk_en(4'he);
    chk_rd(ADDR_QUICK_STATUS, 16'h0010);
    u_host.rd(4'h2, d);
    chk_rd(4'h2, 16'h0000);
    u_host.wr(4'h2, 16'h0001);
    cyc(2);
    chk_en(4'hf);
    $display("test shutdown done");
  endtask : t_shut

  task automatic t_fail();
    @(posedge sys_clk) fail <= 1'b1;
    sd <= 4'h8;
    cyc(252);
    chk_en(4'h7);
    @(posedge sys_clk) sd <= 4'h0;
    u_host.wr(4'h5, 16'h0001);
    cyc(2);
    chk_en(4'h7);
    @(posedge sys_clk) mtr <= 1'b1;
    @(posedge sys_clk) mtr <= 1'b0;
    cyc(2);
    chk_en(4'hf);
    @(posedge sys_clk) fail <= 1'b0;
    chk_rd(4'h5, 16'h0006);
    $display("test fail mode done");
  endtask : t_fail

  // A frozen clock enable must stretch the deglitch count
  task automatic t_freeze();
    @(posedge sys_clk) sd <= 4'h2;
    cyc(200);
    @(posedge sys_clk) ce <= 1'b0;
    cyc(100);
    chk_en(4'hf);
    @(posedge sys_clk) ce <= 1'b1;
    cyc(45);
    chk_en(4'hf);
    cyc(10);
    chk_en(4'hd);
    @(posedge sys_clk) sd <= 4'h0;
    chk_rd(4'h3, 16'h0002);
    u_host.wr(4'h3, 16'h0001);
    cyc(2);
    chk_en(4'hf);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_blank();
    @(posedge sys_clk) wake <= 1'b1;
    @(posedge sys_clk) wake <= 1'b0;
    sd <= 4'h1;
    cyc(300);
    chk_en(4'hf);
    @(posedge sys_clk) sd <= 4'h0;
    chk_rd(ADDR_QUICK_STATUS, 16'h0000);
    $display("test blanking done");
  endtask : t_blank

  initial begin
    #1_000_000;
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    chk_rd(ADDR_INIT, 16'h0000);
    chk_en(4'h0);
    // Detection is blind for 2500 cycles after reset
    cyc(2600);
    t_warn();
    t_shut();
    t_fail();
    t_freeze();
    t_blank();
    complete_run();
  end
endmodule : tb_otp_thermal

`default_nettype wire
